// *** hbpd_decoder.sv ***
// half-bridge pwm decoder: pin synchroniser, per-bridge decode and measurement
//
// How it works
// - mode 11 actively holds both switches off
// - split off: one current per phase
// - split on: each phase has two sub-phases
// - short on/off time: pwm switch is active
// - short on/off time, three inputs: opposite switch stays off
// - report delays of pwm or detected active switch
// - rise end missed before blanking: rise zero
// - fall end missed before cross-conduction: fall zero
// - short on/off time: all four delays zero
// - six inputs: each switch from own pin
// - six inputs, mode 00: both off passively
// - six inputs, mode 01: low side active
// - six inputs, mode 10: high side active
// - detection enabled, no short time: active side from detector
// - six inputs: pins 1/2, 3/4, 5/6 per bridge
// - six inputs: high xor low selects switch
// - three inputs: pins 1, 3, 5 per bridge
// - three inputs, mode 01: pin drives low side
// - three inputs, mode 10: high on, low freewheels
// - active freewheel needs bit, enable, three inputs
`timescale 1ns/100ps
`default_nettype none

module hbpd_bridge
(
   input  wire logic       clk_sys_in,
   input  wire logic       reset_in,
   input  wire logic       clk_en_in,
   input  wire logic       pwm_hi_in,
   input  wire logic       pwm_lo_in,
   input  wire logic       six_sel_in,
   input  wire logic [1:0] mode_in,
   input  wire logic       pwm_en_in,
   input  wire logic       afw_en_in,
   input  wire logic       fwd_en_in,
   input  wire logic       det_hs_in,
   input  wire logic       split_in,
   input  wire logic [7:0] ccp_fw_in,
   input  wire logic [7:0] ccp_act_in,
   input  wire logic [7:0] blank_in,
   input  wire logic [7:0] tpchg_in,
   input  wire logic [7:0] tpdchg_in,
   input  wire logic       sw_edge_in,
   input  wire logic       sw_done_in,
   output logic            hs_out,
   output logic            ls_out,
   output logic            hold_off_out,
   output logic            act_hi_out,
   output logic            pchg_out,
   output logic            pchg2_out,
   output logic            pdchg_out,
   output logic            pdchg2_out,
   output logic [31:0]     report_out
);

   typedef struct packed
   {
      logic                  hs;
      logic                  ls;
      logic                  hold;
      logic                  act_hi;
      logic                  act_on;
      logic                  pwm_prev;
      logic                  short_on;
      logic                  short_off;
      logic                  pchg;
      logic                  pchg2;
      logic                  pdchg;
      logic                  pdchg2;
      hbpd_pkg::hbpd_meas_t  st;
      logic [7:0]            cnt;
      logic [7:0]            seg;
      logic [7:0]            dead;
      logic [7:0]            ton;
      logic [7:0]            toff;
      logic [7:0]            rise;
      logic [7:0]            fall;
   } hbpd_br_state_t;

   hbpd_br_state_t q;
   hbpd_br_state_t n;
   logic           pwm_lvl;
   logic           pwm_is_hi;
   logic           short_c;
   logic           afw_on;
   logic           want_hs;
   logic           want_ls;
   logic           act_now;
   logic           mode_pwm;

   always_comb
   begin
      n         = q;
      pwm_is_hi = (mode_in == hbpd_pkg::MODE_HIGH);
      mode_pwm  = (mode_in == hbpd_pkg::MODE_LOW) || pwm_is_hi;
      pwm_lvl   = (six_sel_in && !pwm_is_hi) ? pwm_lo_in : pwm_hi_in;
      short_c   = q.short_on | q.short_off;
      afw_on    = afw_en_in & pwm_en_in & ~six_sel_in;
      act_now   = q.act_hi ? q.hs : q.ls;
      want_hs   = 1'b0;
      want_ls   = 1'b0;
      // on/off length of the pwm switch input
      if (pwm_lvl != q.pwm_prev)
      begin
         if (q.pwm_prev)
         begin
            n.short_on = (q.seg < ccp_fw_in);
         end
         else
         begin
            n.short_off = (q.seg < ccp_act_in);
         end
         n.seg = hbpd_pkg::CNT_ONE;
      end
      else if (q.seg != hbpd_pkg::CNT_MAX)
      begin
         n.seg = 8'(q.seg + hbpd_pkg::CNT_ONE);
      end
      n.pwm_prev = pwm_lvl;
      n.hold = (mode_in == hbpd_pkg::MODE_HOLD);
      // mode 00 and disabled bridges fall through to off
      if (mode_pwm && pwm_en_in)
      begin
         if (six_sel_in)
         begin
            want_hs = pwm_hi_in & ~pwm_lo_in;
            want_ls = pwm_lo_in & ~pwm_hi_in;
         end
         else if (!pwm_is_hi)
         begin
            want_ls = pwm_hi_in;
            want_hs = afw_on & ~pwm_hi_in & ~short_c;
         end
         else
         begin
            want_hs = pwm_hi_in;
            want_ls = afw_on & ~pwm_hi_in & ~short_c;
         end
      end
      // cross-conduction gap only with active freewheel
      if (!afw_on)
      begin
         n.dead = hbpd_pkg::CNT_ZERO;
         n.hs   = want_hs;
         n.ls   = want_ls;
      end
      else if (q.dead != hbpd_pkg::CNT_ZERO)
      begin
         n.dead = 8'(q.dead - hbpd_pkg::CNT_ONE);
         n.hs   = 1'b0;
         n.ls   = 1'b0;
      end
      else if ((want_hs && q.ls) || (want_ls && q.hs))
      begin
         n.dead = ccp_act_in;
         n.hs   = 1'b0;
         n.ls   = 1'b0;
      end
      else
      begin
         n.hs = want_hs;
         n.ls = want_ls;
      end
      if (fwd_en_in && !short_c)
      begin
         n.act_hi = det_hs_in;
      end
      else
      begin
         n.act_hi = pwm_is_hi;
      end
      n.act_on = act_now;
      if (act_now && !q.act_on)
      begin
         n.st  = hbpd_pkg::MEAS_TON;
         n.cnt = hbpd_pkg::CNT_ZERO;
      end
      else if (!act_now && q.act_on)
      begin
         n.st  = hbpd_pkg::MEAS_TOFF;
         n.cnt = hbpd_pkg::CNT_ZERO;
      end
      else
      begin
         if (q.cnt != hbpd_pkg::CNT_MAX)
         begin
            n.cnt = 8'(q.cnt + hbpd_pkg::CNT_ONE);
         end
         case (q.st)
            hbpd_pkg::MEAS_TON:
            begin
               if (sw_edge_in)
               begin
                  n.ton = q.cnt;
                  n.st  = hbpd_pkg::MEAS_RISE;
                  n.cnt = hbpd_pkg::CNT_ZERO;
               end
            end
            hbpd_pkg::MEAS_RISE:
            begin
               if (sw_done_in)
               begin
                  n.rise = q.cnt;
                  n.st   = hbpd_pkg::MEAS_IDLE;
               end
               else if (q.cnt >= blank_in)
               begin
                  n.rise = hbpd_pkg::CNT_ZERO;
                  n.st   = hbpd_pkg::MEAS_IDLE;
               end
            end
            hbpd_pkg::MEAS_TOFF:
            begin
               if (sw_edge_in)
               begin
                  n.toff = q.cnt;
                  n.st   = hbpd_pkg::MEAS_FALL;
                  n.cnt  = hbpd_pkg::CNT_ZERO;
               end
            end
            hbpd_pkg::MEAS_FALL:
            begin
               if (sw_done_in)
               begin
                  n.fall = q.cnt;
                  n.st   = hbpd_pkg::MEAS_IDLE;
               end
               else if (q.cnt >= ccp_act_in)
               begin
                  n.fall = hbpd_pkg::CNT_ZERO;
                  n.st   = hbpd_pkg::MEAS_IDLE;
               end
            end
            default:
            begin
               n.st = hbpd_pkg::MEAS_IDLE;
            end
         endcase
      end
      if (short_c)
      begin
         n.ton  = hbpd_pkg::CNT_ZERO;
         n.toff = hbpd_pkg::CNT_ZERO;
         n.rise = hbpd_pkg::CNT_ZERO;
         n.fall = hbpd_pkg::CNT_ZERO;
      end
      n.pchg   = (n.st == hbpd_pkg::MEAS_TON) && (n.cnt < tpchg_in);
      n.pchg2  = n.pchg && split_in && (n.cnt >= (tpchg_in >> 1));
      n.pdchg  = (n.st == hbpd_pkg::MEAS_TOFF) && (n.cnt < tpdchg_in);
      n.pdchg2 = n.pdchg && split_in && (n.cnt >= (tpdchg_in >> 1));
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         q <= '0;
      end
      else if (clk_en_in)
      begin
         q <= n;
      end
   end

   assign hs_out       = q.hs;
   assign ls_out       = q.ls;
   assign hold_off_out = q.hold;
   assign act_hi_out   = q.act_hi;
   assign pchg_out     = q.pchg;
   assign pchg2_out    = q.pchg2;
   assign pdchg_out    = q.pdchg;
   assign pdchg2_out   = q.pdchg2;
   assign report_out   = {q.fall, q.rise, q.toff, q.ton};

   sequence s_rise_late;
      clk_en_in && (act_now == q.act_on) && (q.st == hbpd_pkg::MEAS_RISE)
         && !sw_done_in && (q.cnt >= blank_in);
   endsequence

   sequence s_fall_late;
      clk_en_in && (act_now == q.act_on) && (q.st == hbpd_pkg::MEAS_FALL)
         && !sw_done_in && (q.cnt >= ccp_act_in);
   endsequence

   property p_hold_off;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && mode_in == hbpd_pkg::MODE_HOLD) |=> (!q.hs && !q.ls && q.hold);
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("hold mode left a switch on");

   property p_six_off;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && six_sel_in && mode_in == hbpd_pkg::MODE_OFF)
         |=> (!q.hs && !q.ls && !q.hold);
   endproperty
   a_six_off: assert property (p_six_off) else $error("mode 00 not passive off");

   property p_six_pair;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && six_sel_in && pwm_en_in && mode_pwm)
         |=> (q.hs == $past(pwm_hi_in && !pwm_lo_in)) && (q.ls == $past(pwm_lo_in && !pwm_hi_in));
   endproperty
   a_six_pair: assert property (p_six_pair) else $error("six-input decode wrong");

   property p_three_low;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && !six_sel_in && pwm_en_in && !afw_en_in
         && mode_in == hbpd_pkg::MODE_LOW) |=> (q.ls == $past(pwm_hi_in)) && !q.hs;
   endproperty
   a_three_low: assert property (p_three_low) else $error("mode 01 low side decode wrong");

   property p_three_high;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && !six_sel_in && pwm_en_in && mode_in == hbpd_pkg::MODE_HIGH
         && pwm_hi_in) |=> (q.hs || $past(q.dead != hbpd_pkg::CNT_ZERO || q.ls)) && !q.ls;
   endproperty
   a_three_high: assert property (p_three_high) else $error("mode 10 high side decode wrong");

   property p_short_passive;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && short_c && !six_sel_in && mode_in == hbpd_pkg::MODE_HIGH)
         |=> !q.ls;
   endproperty
   a_short_passive: assert property (p_short_passive) else $error("freewheel on at short time");

   property p_short_active;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && short_c) |=> (q.act_hi == $past(pwm_is_hi));
   endproperty
   a_short_active: assert property (p_short_active) else $error("short time active side wrong");

   property p_detect;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && fwd_en_in && !short_c) |=> (q.act_hi == $past(det_hs_in));
   endproperty
   a_detect: assert property (p_detect) else $error("detector result not used");

   property p_six_low_active;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && six_sel_in && !fwd_en_in && mode_in == hbpd_pkg::MODE_LOW) |=> !q.act_hi;
   endproperty
   a_six_low_active: assert property (p_six_low_active) else $error("low side not active");

   property p_six_high_active;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && six_sel_in && !fwd_en_in && mode_in == hbpd_pkg::MODE_HIGH) |=> q.act_hi;
   endproperty
   a_six_high_active: assert property (p_six_high_active) else $error("high side not active");

   property p_rise_zero;
      @(posedge clk_sys_in) disable iff (reset_in)
      s_rise_late |=> (q.rise == hbpd_pkg::CNT_ZERO) && (q.st == hbpd_pkg::MEAS_IDLE);
   endproperty
   a_rise_zero: assert property (p_rise_zero) else $error("late rise not zeroed");

   property p_fall_zero;
      @(posedge clk_sys_in) disable iff (reset_in)
      s_fall_late |=> (q.fall == hbpd_pkg::CNT_ZERO) && (q.st == hbpd_pkg::MEAS_IDLE);
   endproperty
   a_fall_zero: assert property (p_fall_zero) else $error("late fall not zeroed");

   property p_short_report;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && short_c) |=> (report_out == hbpd_pkg::REPORT_RST);
   endproperty
   a_short_report: assert property (p_short_report) else $error("report not zero at short time");

   property p_single_phase;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && !split_in) |=> (!q.pchg2 && !q.pdchg2);
   endproperty
   a_single_phase: assert property (p_single_phase) else $error("sub-phase without split");

   property p_split_phase;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && split_in && (act_now == q.act_on) && (q.st == hbpd_pkg::MEAS_TON)
         && !sw_edge_in && (q.cnt != hbpd_pkg::CNT_MAX)
         && (8'(q.cnt + hbpd_pkg::CNT_ONE) < tpchg_in)
         && (8'(q.cnt + hbpd_pkg::CNT_ONE) >= (tpchg_in >> 1))) |=> q.pchg2;
   endproperty
   a_split_phase: assert property (p_split_phase) else $error("second sub-phase missing");

   property p_no_gap;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in && !afw_on) |=> (q.dead == hbpd_pkg::CNT_ZERO);
   endproperty
   a_no_gap: assert property (p_no_gap) else $error("gap without active freewheel");

endmodule : hbpd_bridge

module hbpd_decoder
(
   input  wire logic        clk_sys_in,
   input  wire logic        reset_in,
   input  wire logic        clk_en_in,
   input  wire logic        pwm_in_one_in,
   input  wire logic        pwm_in_two_in,
   input  wire logic        pwm_in_three_in,
   input  wire logic        pwm_in_four_in,
   input  wire logic        pwm_in_five_in,
   input  wire logic        pwm_in_six_in,
   input  wire logic        six_input_select_in,
   input  wire logic [5:0]  bridge_mode_field_in,
   input  wire logic [2:0]  bridge_pwm_enable_in,
   input  wire logic [2:0]  active_freewheel_enable_in,
   input  wire logic        freewheel_detect_enable_in,
   input  wire logic [2:0]  freewheel_detect_hs_active_in,
   input  wire logic        split_precharge_enable_in,
   input  wire logic [7:0]  ccp_fw_cycles_in,
   input  wire logic [7:0]  ccp_active_cycles_in,
   input  wire logic [7:0]  blank_active_cycles_in,
   input  wire logic [7:0]  precharge_time_in,
   input  wire logic [7:0]  predischarge_time_in,
   input  wire logic [2:0]  switch_edge_in,
   input  wire logic [2:0]  switch_done_in,
   output logic [2:0]       high_side_switch_out,
   output logic [2:0]       low_side_switch_out,
   output logic [2:0]       actively_off_out,
   output logic [2:0]       active_is_high_out,
   output logic [2:0]       precharge_out,
   output logic [2:0]       precharge_second_out,
   output logic [2:0]       predischarge_out,
   output logic [2:0]       predischarge_second_out,
   output logic [31:0]      measured_delay_bridge1_out,
   output logic [31:0]      measured_delay_bridge2_out,
   output logic [31:0]      measured_delay_bridge3_out
);

   typedef struct packed
   {
      logic [5:0] s1;
      logic [5:0] s2;
   } hbpd_sync_t;

   hbpd_sync_t  q;
   hbpd_sync_t  n;
   logic [5:0]  pins_now;
   logic [31:0] rep [3];

   assign pins_now = {pwm_in_six_in, pwm_in_five_in, pwm_in_four_in,
                      pwm_in_three_in, pwm_in_two_in, pwm_in_one_in};

   always_comb
   begin
      n    = q;
      n.s1 = pins_now;
      n.s2 = q.s1;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         q <= '0;
      end
      else if (clk_en_in)
      begin
         q <= n;
      end
   end

   property p_sync;
      @(posedge clk_sys_in) disable iff (reset_in)
      (clk_en_in ##1 clk_en_in) |=> (q.s2 == $past(pins_now, 2));
   endproperty
   a_sync: assert property (p_sync) else $error("pin synchroniser latency wrong");

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_br
         // odd pin high, even pin low
         hbpd_bridge u_br
         (
            .clk_sys_in (clk_sys_in),
            .reset_in   (reset_in),
            .clk_en_in  (clk_en_in),
            .pwm_hi_in  (q.s2[2*gi]),
            .pwm_lo_in  (q.s2[2*gi+1]),
            .six_sel_in (six_input_select_in),
            .mode_in    (bridge_mode_field_in[2*gi +: 2]),
            .pwm_en_in  (bridge_pwm_enable_in[gi]),
            .afw_en_in  (active_freewheel_enable_in[gi]),
            .fwd_en_in  (freewheel_detect_enable_in),
            .det_hs_in  (freewheel_detect_hs_active_in[gi]),
            .split_in   (split_precharge_enable_in),
            .ccp_fw_in  (ccp_fw_cycles_in),
            .ccp_act_in (ccp_active_cycles_in),
            .blank_in   (blank_active_cycles_in),
            .tpchg_in   (precharge_time_in),
            .tpdchg_in  (predischarge_time_in),
            .sw_edge_in (switch_edge_in[gi]),
            .sw_done_in (switch_done_in[gi]),
            .hs_out       (high_side_switch_out[gi]),
            .ls_out       (low_side_switch_out[gi]),
            .hold_off_out (actively_off_out[gi]),
            .act_hi_out   (active_is_high_out[gi]),
            .pchg_out     (precharge_out[gi]),
            .pchg2_out    (precharge_second_out[gi]),
            .pdchg_out    (predischarge_out[gi]),
            .pdchg2_out   (predischarge_second_out[gi]),
            .report_out   (rep[gi])
         );
      end
   endgenerate

   assign measured_delay_bridge1_out = rep[0];
   assign measured_delay_bridge2_out = rep[1];
   assign measured_delay_bridge3_out = rep[2];

endmodule : hbpd_decoder

`default_nettype wire

// *** hbpd_decoder_tb.sv ***
// self-checking bench for the half-bridge pwm decoder
`timescale 1ns/100ps
`default_nettype none
module hbpd_decoder_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        six = 1'b0, fwd = 1'b0, split = 1'b0, clr = 1'b0, on;
   logic [5:0]  lvl = '0, mode = '0, pin;
   logic [2:0]  en = '0, afw = '0, det = '0, edg = '0, done = '0;
   logic [7:0]  ccf = '0, cca = '0, blank = '0, tpc = '0;
   logic [2:0]  hs, ls, aoff, ahi, pc, pc2;
   logic [31:0] rep, top;
   logic        pre_seen = 1'b0, sec_seen = 1'b0;
   logic [31:0] exp_q[$];
   logic [15:0] obs, m, e;
   logic [1:0]  md;
   int          n_fail = 0, tests_run = 0;
   event        smp;

   always #5 clk = ~clk;

   hbpd_host u_host (.clk_sys_in(clk), .level_in(lvl), .pin_out(pin));

   hbpd_decoder u_dut
   (
      .clk_sys_in(clk), .reset_in(rst), .clk_en_in(ce),
      .pwm_in_one_in(pin[0]), .pwm_in_two_in(pin[1]), .pwm_in_three_in(pin[2]),
      .pwm_in_four_in(pin[3]), .pwm_in_five_in(pin[4]), .pwm_in_six_in(pin[5]),
      .six_input_select_in(six), .bridge_mode_field_in(mode),
      .bridge_pwm_enable_in(en), .active_freewheel_enable_in(afw),
      .freewheel_detect_enable_in(fwd), .freewheel_detect_hs_active_in(det),
      .split_precharge_enable_in(split), .ccp_fw_cycles_in(ccf),
      .ccp_active_cycles_in(cca), .blank_active_cycles_in(blank),
      .precharge_time_in(tpc), .predischarge_time_in(8'h04),
      .switch_edge_in(edg), .switch_done_in(done),
      .high_side_switch_out(hs), .low_side_switch_out(ls),
      .actively_off_out(aoff), .active_is_high_out(ahi),
      .precharge_out(pc), .precharge_second_out(pc2),
      .predischarge_out(), .predischarge_second_out(),
      .measured_delay_bridge1_out(rep), .measured_delay_bridge2_out(),
      .measured_delay_bridge3_out()
   );

   assign obs = {sec_seen, pre_seen, rep[31:24] == 8'h00, rep[23:16] == 8'h00,
                 ahi, aoff, ls, hs};

   always @(posedge clk)
   begin
      if (clr)
      begin
         pre_seen <= 1'b0;
         sec_seen <= 1'b0;
      end
      else
      begin
         if (pc[0]) pre_seen <= 1'b1;
         if (pc2[0]) sec_seen <= 1'b1;
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk

   // monitor takes the oldest note when a result is due
   always @(smp)
   begin
      top = exp_q.pop_front();
      chk(obs & top[31:16], top[15:0]);
   end

   task automatic note(input logic [15:0] mk, input logic [15:0] ex);
      exp_q.push_back({mk, ex & mk});
      -> smp;
   endtask : note

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      #100000;
      n_fail++;
      end_of_test();
   end

   initial
   begin
      void'($urandom(90));
      cyc(3);
      rst = 1'b0;
      six = 1'b1;
      for (int k = 0; k < 48; k++)
      begin
         {mode, lvl, en, afw, det, fwd} = 22'($urandom);
         ce = 1'b0;
         cyc(2);
         ce = 1'b1;
         cyc(5);
         m = 16'h01ff;
         e = '0;
         for (int b = 0; b < 3; b++)
         begin
            md = mode[2*b+:2];
            on = en[b] && (md == hbpd_pkg::MODE_LOW || md == hbpd_pkg::MODE_HIGH);
            e[b] = on & lvl[2*b] & ~lvl[2*b+1];
            e[3+b] = on & lvl[2*b+1] & ~lvl[2*b];
            e[6+b] = (md == hbpd_pkg::MODE_HOLD);
            e[9+b] = fwd ? det[b] : (md == hbpd_pkg::MODE_HIGH);
            m[9+b] = on;
         end
         note(m, e); // six-input decode
      end
      six = 1'b0;
      fwd = 1'b0;
      cca = 8'h02;
      for (int k = 0; k < 24; k++)
      begin
         for (int b = 0; b < 3; b++)
            mode[2*b+:2] = 2'($urandom_range(1, 2));
         {lvl, en, afw} = 12'($urandom);
         cyc(8);
         m = 16'h003f;
         e = '0;
         for (int b = 0; b < 3; b++)
         begin
            on = en[b] & lvl[2*b];
            e[b] = (mode[2*b+:2] == hbpd_pkg::MODE_HIGH) ? on :
                   en[b] & afw[b] & ~lvl[2*b];
            e[3+b] = (mode[2*b+:2] == hbpd_pkg::MODE_LOW) ? on :
                     en[b] & afw[b] & ~lvl[2*b];
         end
         note(m, e); // three-input decode
      end
      mode = 6'h02;
      en = 3'h1;
      afw = 3'h1;
      fwd = 1'b1;
      det = 3'h0;
      ccf = 8'h14;
      lvl = '0;
      cyc(30);
      lvl[0] = 1'b1;
      cyc(3);
      lvl[0] = 1'b0;
      cyc(8);
      note(16'h3208, 16'h3200); // short on-time
      six = 1'b1;
      fwd = 1'b0;
      ccf = 8'h00;
      cca = 8'h05;
      blank = 8'h05;
      tpc = 8'h06;
      for (int s = 0; s < 2; s++)
      begin
         split = s[0];
         cyc(20);
         clr = 1'b1;
         cyc(1);
         clr = 1'b0;
         lvl[0] = 1'b1;
         cyc(12);
         edg[0] = 1'b1;
         cyc(1);
         edg[0] = 1'b0;
         cyc(2);
         done[0] = split;
         cyc(1);
         done[0] = 1'b0;
         cyc(10);
         lvl[0] = 1'b0;
         cyc(6);
         edg[0] = 1'b1;
         cyc(1);
         edg[0] = 1'b0;
         cyc(12);
         note(16'hf000, {split, 3'b110 | {2'b00, ~split}, 12'h000});
      end
      cyc(2);
      end_of_test();
   end
endmodule : hbpd_decoder_tb
`default_nettype wire

// *** hbpd_host.sv ***
// host model driving the six pwm pins
`timescale 1ns/100ps
`default_nettype none
module hbpd_host
(
   input  wire logic       clk_sys_in,
   input  wire logic [5:0] level_in,
   output logic [5:0]      pin_out
);
   always_ff @(posedge clk_sys_in)
   begin
      pin_out <= level_in;
   end
endmodule : hbpd_host
`default_nettype wire

// *** hbpd_pkg.sv ***
// shared constants and types for the half-bridge pwm decoder
package hbpd_pkg;

   // widths and counts
   localparam int unsigned CNT_W    = 8;
   localparam int unsigned REPORT_W = 32;
   localparam int unsigned BRIDGES  = 3;
   localparam int unsigned PINS     = 6;

   // bridge mode field codes
   localparam logic [1:0] MODE_OFF  = 2'h0;
   localparam logic [1:0] MODE_LOW  = 2'h1;
   localparam logic [1:0] MODE_HIGH = 2'h2;
   localparam logic [1:0] MODE_HOLD = 2'h3;

   // measured delay report field positions
   localparam int unsigned TON_LSB  = 0;
   localparam int unsigned TOFF_LSB = 8;
   localparam int unsigned RISE_LSB = 16;
   localparam int unsigned FALL_LSB = 24;

   // reset and saturation values
   localparam logic [CNT_W-1:0]    CNT_ZERO   = 8'h00;
   localparam logic [CNT_W-1:0]    CNT_ONE    = 8'h01;
   localparam logic [CNT_W-1:0]    CNT_MAX    = 8'hff;
   localparam logic [REPORT_W-1:0] REPORT_RST = 32'h0000_0000;

   // switching measurement states
   typedef enum logic [2:0]
   {
      MEAS_IDLE = 3'b000,
      MEAS_TON  = 3'b001,
      MEAS_RISE = 3'b010,
      MEAS_TOFF = 3'b011,
      MEAS_FALL = 3'b100
   } hbpd_meas_t;

endpackage : hbpd_pkg
